// *** hw/decoder_ctrl_pkg.sv ***
package decoder_ctrl_pkg;
  localparam logic [7:0] ADDR_DELAY      = 8'h29;
  localparam logic [7:0] ADDR_BRIGHT     = 8'h2A;
  localparam logic [7:0] ADDR_CONTRAST   = 8'h2B;
  localparam logic [7:0] ADDR_SATUR      = 8'h2C;
  localparam logic [7:0] ADDR_MASK1      = 8'h2D;
  localparam logic [7:0] ADDR_MASK2      = 8'h2E;
  localparam logic [7:0] ADDR_MASK3      = 8'h2F;
  localparam logic [7:0] ADDR_AUDIO_CYCLES_PER_FIELD_LO    = 8'h30;
  localparam logic [7:0] ADDR_AUDIO_CYCLES_PER_FIELD_MID   = 8'h31;
  localparam logic [7:0] ADDR_AUDIO_CYCLES_PER_FIELD_HI    = 8'h32;
  localparam logic [7:0] ADDR_AUDIO_NOMINAL_INCREMENT_LO    = 8'h34;
  localparam logic [7:0] ADDR_AUDIO_NOMINAL_INCREMENT_MID   = 8'h35;
  localparam logic [7:0] ADDR_AUDIO_NOMINAL_INCREMENT_HI    = 8'h36;
  localparam logic [7:0] RST_DELAY       = 8'h00;
  localparam logic [7:0] RST_BRIGHT      = 8'h80;
  localparam logic [7:0] RST_GAIN        = 8'h40;
  localparam logic [7:0] RST_MASK        = 8'h00;
  localparam logic [7:0] RST_WORD        = 8'h00;
  localparam logic [7:0] MASK1_USED      = 8'h1D;
  localparam logic [7:0] MASK2_USED      = 8'h43;
  localparam logic [7:0] MASK3_USED      = 8'hEF;
  localparam logic [7:0] AUDIO_CYCLES_PER_FIELD_HI_USED    = 8'h03;
  localparam logic [7:0] AUDIO_NOMINAL_INCREMENT_HI_USED    = 8'h3F;
  localparam int         DELAY_LSB       = 0;
  localparam int         AUDIO_CYCLES_PER_FIELD_W          = 18;
  localparam int         AUDIO_NOMINAL_INCREMENT_W          = 22;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] flags_60;
    logic [7:0] flags_8f;
    logic [7:0] flags_1e;
    logic [7:0] flags_1f;
  } status_flags_t;

  typedef struct packed {
    logic signed [5:0] delay_pix;
    logic        [7:0] comp_brightness_offset;
    logic signed [7:0] comp_contrast_gain;
    logic signed [7:0] comp_saturation_gain;
    logic [AUDIO_CYCLES_PER_FIELD_W-1:0] audio_cycles_per_field;
    logic [AUDIO_NOMINAL_INCREMENT_W-1:0] audio_nominal_increment;
    logic              audio_clk_field_locked;
  } video_ctrl_t;
endpackage : decoder_ctrl_pkg

// *** hw/irq_change_detect.sv ***
`timescale 1ns/1ps
module irq_change_detect (
  input  wire logic                           sys_clk,
  input  wire logic                           sys_rst,
  input  wire decoder_ctrl_pkg::status_flags_t flags,
  input  wire decoder_ctrl_pkg::status_flags_t masks,
  output logic                                change_hit
);
  import decoder_ctrl_pkg::*;
  status_flags_t prev_reg;
  status_flags_t prev_next;
  logic          hit_next;

  always_comb begin
    prev_next = flags;
    // only enabled flags may raise it; disabled edges are ignored
    hit_next  = |((flags ^ prev_reg) & masks);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prev_reg   <= '0;
      change_hit <= 1'b0;
    end else begin
      prev_reg   <= prev_next;
      change_hit <= hit_next;
    end
  end
endmodule : irq_change_detect

// *** hw/decoder_ctrl_regs.sv ***
`timescale 1ns/1ps
module decoder_ctrl_regs (
  input  wire logic                            sys_clk,
  input  wire logic                            sys_rst,
  input  wire decoder_ctrl_pkg::reg_req_t      req,
  input  wire decoder_ctrl_pkg::status_flags_t status_flags,
  input  wire logic                            audio_pll_open,
  output logic [7:0]                           rdata,
  output decoder_ctrl_pkg::video_ctrl_t        ctrl,
  output logic                                 irq_req
);
  import decoder_ctrl_pkg::*;

  logic [7:0]    delay_reg, delay_next;
  logic [7:0]    bright_reg, bright_next;
  logic [7:0]    contrast_reg, contrast_next;
  logic [7:0]    satur_reg, satur_next;
  logic [7:0]    mask1_reg, mask1_next;
  logic [7:0]    mask2_reg, mask2_next;
  logic [7:0]    mask3_reg, mask3_next;
  logic [7:0]    audio_cycles_per_field_lo_reg, audio_cycles_per_field_lo_next;
  logic [7:0]    audio_cycles_per_field_mid_reg, audio_cycles_per_field_mid_next;
  logic [7:0]    audio_cycles_per_field_hi_reg, audio_cycles_per_field_hi_next;
  logic [7:0]    audio_nominal_increment_lo_reg, audio_nominal_increment_lo_next;
  logic [7:0]    audio_nominal_increment_mid_reg, audio_nominal_increment_mid_next;
  logic [7:0]    audio_nominal_increment_hi_reg, audio_nominal_increment_hi_next;
  logic [7:0]    rdata_next;
  logic          pll_open_meta, pll_open_sync;
  video_ctrl_t   ctrl_next;
  status_flags_t flag_sync1, flag_sync2;
  status_flags_t mask_map;
  logic          change_hit;

  function automatic logic signed [5:0] delay_decode(input logic [2:0] code);
    // negative half steps by 4 from -16 upward
    unique case (code)
      3'h0:    delay_decode = 6'sd0;
      3'h1:    delay_decode = 6'sd4;
      3'h2:    delay_decode = 6'sd8;
      3'h3:    delay_decode = 6'sd12;
      3'h4:    delay_decode = -6'sd16;
      3'h5:    delay_decode = -6'sd12;
      3'h6:    delay_decode = -6'sd8;
      3'h7:    delay_decode = -6'sd4;
      default: delay_decode = 6'sd0;
    endcase
  endfunction : delay_decode

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = req.wr_en && (a == b);
  endfunction : hit

  always_comb begin
    delay_next    = hit(req.addr, ADDR_DELAY)    ? req.wdata : delay_reg;
    bright_next   = hit(req.addr, ADDR_BRIGHT)   ? req.wdata : bright_reg;
    contrast_next = hit(req.addr, ADDR_CONTRAST) ? req.wdata : contrast_reg;
    satur_next    = hit(req.addr, ADDR_SATUR)    ? req.wdata : satur_reg;
    mask1_next    = hit(req.addr, ADDR_MASK1)    ? (req.wdata & MASK1_USED) : mask1_reg;
    mask2_next    = hit(req.addr, ADDR_MASK2)    ? (req.wdata & MASK2_USED) : mask2_reg;
    mask3_next    = hit(req.addr, ADDR_MASK3)    ? (req.wdata & MASK3_USED) : mask3_reg;
    audio_cycles_per_field_lo_next  = hit(req.addr, ADDR_AUDIO_CYCLES_PER_FIELD_LO)  ? req.wdata : audio_cycles_per_field_lo_reg;
    audio_cycles_per_field_mid_next = hit(req.addr, ADDR_AUDIO_CYCLES_PER_FIELD_MID) ? req.wdata : audio_cycles_per_field_mid_reg;
    // unused upper bits never stored, so they read zero
    audio_cycles_per_field_hi_next  = hit(req.addr, ADDR_AUDIO_CYCLES_PER_FIELD_HI)  ? (req.wdata & AUDIO_CYCLES_PER_FIELD_HI_USED) : audio_cycles_per_field_hi_reg;
    audio_nominal_increment_lo_next  = hit(req.addr, ADDR_AUDIO_NOMINAL_INCREMENT_LO)  ? req.wdata : audio_nominal_increment_lo_reg;
    audio_nominal_increment_mid_next = hit(req.addr, ADDR_AUDIO_NOMINAL_INCREMENT_MID) ? req.wdata : audio_nominal_increment_mid_reg;
    audio_nominal_increment_hi_next  = hit(req.addr, ADDR_AUDIO_NOMINAL_INCREMENT_HI)  ? (req.wdata & AUDIO_NOMINAL_INCREMENT_HI_USED) : audio_nominal_increment_hi_reg;
  end

  always_comb begin
    rdata_next = rdata;
    if (req.rd_en) begin
      unique case (req.addr)
        ADDR_DELAY:    rdata_next = delay_reg;
        ADDR_BRIGHT:   rdata_next = bright_reg;
        ADDR_CONTRAST: rdata_next = contrast_reg;
        ADDR_SATUR:    rdata_next = satur_reg;
        ADDR_MASK1:    rdata_next = mask1_reg;
        ADDR_MASK2:    rdata_next = mask2_reg;
        ADDR_MASK3:    rdata_next = mask3_reg;
        ADDR_AUDIO_CYCLES_PER_FIELD_LO:  rdata_next = audio_cycles_per_field_lo_reg;
        ADDR_AUDIO_CYCLES_PER_FIELD_MID: rdata_next = audio_cycles_per_field_mid_reg;
        ADDR_AUDIO_CYCLES_PER_FIELD_HI:  rdata_next = audio_cycles_per_field_hi_reg;
        ADDR_AUDIO_NOMINAL_INCREMENT_LO:  rdata_next = audio_nominal_increment_lo_reg;
        ADDR_AUDIO_NOMINAL_INCREMENT_MID: rdata_next = audio_nominal_increment_mid_reg;
        ADDR_AUDIO_NOMINAL_INCREMENT_HI:  rdata_next = audio_nominal_increment_hi_reg;
        // addresses outside this bank answer zero
        default:       rdata_next = 8'h00;
      endcase
    end
  end

  always_comb begin
    ctrl_next.delay_pix               = delay_decode(delay_reg[DELAY_LSB +: 3]);
    ctrl_next.comp_brightness_offset  = bright_reg;
    ctrl_next.comp_contrast_gain      = contrast_reg;
    ctrl_next.comp_saturation_gain    = satur_reg;
    ctrl_next.audio_cycles_per_field  = {audio_cycles_per_field_hi_reg[1:0], audio_cycles_per_field_mid_reg, audio_cycles_per_field_lo_reg};
    ctrl_next.audio_nominal_increment = {audio_nominal_increment_hi_reg[5:0], audio_nominal_increment_mid_reg, audio_nominal_increment_lo_reg};
    // bit low: locked to field with cycles-per-field; high: free run
    ctrl_next.audio_clk_field_locked  = ~pll_open_sync;
  end

  // mask bits placed at the position of their status flag
  always_comb begin
    mask_map          = '0;
    mask_map.flags_60 = {3'h0, mask1_reg[4:2], 2'h0};
    mask_map.flags_8f = {5'h00, mask1_reg[0], 2'h0};
    mask_map.flags_1e = {1'b0, mask2_reg[6], 4'h0, mask2_reg[1:0]};
    mask_map.flags_1f = {mask3_reg[7:5], 1'b0, mask3_reg[3:0]};
  end

  irq_change_detect u_irq (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .flags      (flag_sync2),
    .masks      (mask_map),
    .change_hit (change_hit)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      delay_reg    <= RST_DELAY;
      bright_reg   <= RST_BRIGHT;
      contrast_reg <= RST_GAIN;
      satur_reg    <= RST_GAIN;
      mask1_reg    <= RST_MASK;
      mask2_reg    <= RST_MASK;
      mask3_reg    <= RST_MASK;
      audio_cycles_per_field_lo_reg  <= RST_WORD;
      audio_cycles_per_field_mid_reg <= RST_WORD;
      audio_cycles_per_field_hi_reg  <= RST_WORD;
      audio_nominal_increment_lo_reg  <= RST_WORD;
      audio_nominal_increment_mid_reg <= RST_WORD;
      audio_nominal_increment_hi_reg  <= RST_WORD;
      rdata        <= 8'h00;
    end else begin
      delay_reg    <= delay_next;
      bright_reg   <= bright_next;
      contrast_reg <= contrast_next;
      satur_reg    <= satur_next;
      mask1_reg    <= mask1_next;
      mask2_reg    <= mask2_next;
      mask3_reg    <= mask3_next;
      audio_cycles_per_field_lo_reg  <= audio_cycles_per_field_lo_next;
      audio_cycles_per_field_mid_reg <= audio_cycles_per_field_mid_next;
      audio_cycles_per_field_hi_reg  <= audio_cycles_per_field_hi_next;
      audio_nominal_increment_lo_reg  <= audio_nominal_increment_lo_next;
      audio_nominal_increment_mid_reg <= audio_nominal_increment_mid_next;
      audio_nominal_increment_hi_reg  <= audio_nominal_increment_hi_next;
      rdata        <= rdata_next;
    end
  end

  // flags and mode bit may come from other logic; synchronised to be safe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flag_sync1    <= '0;
      flag_sync2    <= '0;
      pll_open_meta <= 1'b0;
      pll_open_sync <= 1'b0;
      ctrl          <= '0;
      irq_req       <= 1'b0;
    end else begin
      flag_sync1    <= status_flags;
      flag_sync2    <= flag_sync1;
      pll_open_meta <= audio_pll_open;
      pll_open_sync <= pll_open_meta;
      ctrl          <= ctrl_next;
      irq_req       <= change_hit;
    end
  end
endmodule : decoder_ctrl_regs

// *** tb/decoder_ctrl_props.sv ***
`timescale 1ns/1ps
module decoder_ctrl_props (
  input wire logic                            sys_clk,
  input wire logic                            sys_rst,
  input wire decoder_ctrl_pkg::reg_req_t      req,
  input wire decoder_ctrl_pkg::status_flags_t status_flags,
  input wire logic                            audio_pll_open,
  input wire logic [7:0]                      rdata,
  input wire decoder_ctrl_pkg::video_ctrl_t   ctrl,
  input wire logic                            irq_req
);
  import decoder_ctrl_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr(logic [7:0] a); req.wr_en && req.addr == a; endsequence
  sequence s_rd(logic [7:0] a); req.rd_en && req.addr == a; endsequence
  // delay code is a multiple of 4 pixels, sign from bit 2
  a_delay_decode: assert property (s_wr(ADDR_DELAY) |-> ##2
    ctrl.delay_pix == {$past(req.wdata[2], 2), $past(req.wdata[2:0], 2), 2'b00})
    else $error("delay decode wrong");
  a_bright_live: assert property (s_wr(ADDR_BRIGHT) |-> ##2
    ctrl.comp_brightness_offset == $past(req.wdata, 2)) else $error("brightness wrong");
  a_contrast_live: assert property (s_wr(ADDR_CONTRAST) |-> ##2
    ctrl.comp_contrast_gain == $past(req.wdata, 2)) else $error("contrast wrong");
  a_satur_live: assert property (s_wr(ADDR_SATUR) |-> ##2
    ctrl.comp_saturation_gain == $past(req.wdata, 2)) else $error("saturation wrong");
  a_audio_cycles_per_field_top: assert property (s_wr(ADDR_AUDIO_CYCLES_PER_FIELD_HI) |-> ##2
    ctrl.audio_cycles_per_field[17:16] == $past(req.wdata[1:0], 2)) else $error("audio_cycles_per_field top wrong");
  a_audio_nominal_increment_top: assert property (s_wr(ADDR_AUDIO_NOMINAL_INCREMENT_HI) |-> ##2
    ctrl.audio_nominal_increment[21:16] == $past(req.wdata[5:0], 2)) else $error("audio_nominal_increment top wrong");
  a_pll_open: assert property ($rose(audio_pll_open) |-> ##[1:5]
    !ctrl.audio_clk_field_locked) else $error("pll open not followed");
  a_pll_locked: assert property ($fell(audio_pll_open) |-> ##[1:5]
    ctrl.audio_clk_field_locked) else $error("pll lock not followed");
  a_irq_cause: assert property (irq_req |->
    $past(status_flags, 4) != $past(status_flags, 5)) else $error("irq without flag change");
  a_mask1_unused: assert property (s_rd(ADDR_MASK1) |=>
    (rdata & ~MASK1_USED) == 8'h00) else $error("mask1 unused bits read back");
  a_unmapped_zero: assert property (s_rd(8'h33) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : decoder_ctrl_props
bind decoder_ctrl_regs decoder_ctrl_props u_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .req(req), .status_flags(status_flags), .audio_pll_open(audio_pll_open), .rdata(rdata),
  .ctrl(ctrl), .irq_req(irq_req));

// *** tb/serial_host_model.sv ***
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic                      sys_clk,
  output decoder_ctrl_pkg::reg_req_t     req
);
  import decoder_ctrl_pkg::*;
  initial req = '0;
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req = '{wr_en: wr, rd_en: !wr, addr: a, wdata: d};
    @(negedge sys_clk);
    req.wr_en = 1'b0;
    req.rd_en = 1'b0;
    // released data is inverted so a stale value never passes
    req.wdata = ~d;
  endtask : xfer
endmodule : serial_host_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import decoder_ctrl_pkg::*;
  logic          sys_clk;
  logic          sys_rst;
  logic          audio_pll_open;
  reg_req_t      req;
  status_flags_t status_flags;
  logic [7:0]    rdata;
  video_ctrl_t   ctrl;
  logic          irq_req;
  int            bad_count = 0;
  int            checked = 0;
  int            n;
  logic [7:0]    adr[13] = '{8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31,
                             8'h32, 8'h34, 8'h35, 8'h36};
  logic [7:0]    rst_v[13] = '{8'h00, 8'h80, 8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]    used[13] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1D, 8'h43, 8'hEF, 8'hFF, 8'hFF,
                              8'h03, 8'hFF, 8'hFF, 8'h3F};
  logic [5:0]    dpix[8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h30, 6'h34, 6'h38, 6'h3C};
  logic [7:0]    gains[5] = '{8'h7F, 8'h40, 8'h00, 8'hC0, 8'h80};
  logic [31:0]   irq_en = 32'h1C04_43EF;
  serial_host_model host (.sys_clk(sys_clk), .req(req));
  decoder_ctrl_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req),
    .status_flags(status_flags), .audio_pll_open(audio_pll_open), .rdata(rdata),
    .ctrl(ctrl), .irq_req(irq_req));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00);
    chk({14'h0000, rdata}, {14'h0000, e});
  endtask : rd
  // toggle one flag bit and count pulses; latency is 4 so 8 cycles is ample
  task automatic flip(input int b, output int cnt);
    cnt = 0;
    @(negedge sys_clk) status_flags = status_flags ^ (32'h1 << b);
    repeat (8) @(negedge sys_clk) cnt += int'(irq_req === 1'b1);
  endtask : flip
  task summarize;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    #50000;
    bad_count++;
    summarize();
  end
  initial begin
    sys_rst = 1'b1;
    audio_pll_open = 1'b0;
    status_flags = '0;
    repeat (5) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({14'h0000, ctrl.comp_brightness_offset}, 22'h80);
    chk({14'h0000, ctrl.comp_contrast_gain}, 22'h40);
    chk({21'h0, ctrl.audio_clk_field_locked}, 22'h1);
    foreach (adr[i]) rd(adr[i], rst_v[i]);
    foreach (adr[i]) begin
      host.xfer(1'b1, adr[i], 8'hFF);
      rd(adr[i], used[i]);
    end
    host.xfer(1'b1, 8'h33, 8'hFF);
    rd(8'h33, 8'h00);
    for (int i = 0; i < 8; i++) begin
      host.xfer(1'b1, 8'h29, 8'(i));
      repeat (2) @(negedge sys_clk);
      chk({16'h0000, ctrl.delay_pix}, {16'h0000, dpix[i]});
    end
    foreach (gains[i]) begin
      host.xfer(1'b1, 8'h2B, gains[i]);
      host.xfer(1'b1, 8'h2C, ~gains[i]);
      repeat (2) @(negedge sys_clk);
      chk({14'h0000, ctrl.comp_contrast_gain}, {14'h0000, gains[i]});
      chk({14'h0000, ctrl.comp_saturation_gain}, {14'h0000, ~gains[i]});
    end
    // bytes F2 FB FC to 30h..32h, 85 8E 97 to 34h..36h; unused top bits dropped
    foreach (adr[i])
      if (adr[i] >= 8'h30) host.xfer(1'b1, adr[i], 8'hC3 ^ 8'(i * 7));
    repeat (2) @(negedge sys_clk);
    chk({4'h0, ctrl.audio_cycles_per_field}, 22'h00FBF2);
    chk(ctrl.audio_nominal_increment, 22'h178E85);
    audio_pll_open = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk({21'h0, ctrl.audio_clk_field_locked}, 22'h0);
    audio_pll_open = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk({21'h0, ctrl.audio_clk_field_locked}, 22'h1);
    for (int b = 0; b < 32; b++) begin
      flip(b, n);
      chk(22'(n), {21'h0, irq_en[b]});
      flip(b, n);
      chk(22'(n), {21'h0, irq_en[b]});
    end
    for (int i = 4; i < 7; i++) host.xfer(1'b1, adr[i], 8'h00);
    for (int b = 0; b < 32; b++) begin
      flip(b, n);
      chk(22'(n), 22'h0);
    end
    summarize();
  end
endmodule : tb
